/* File: hdl/qoshc_ctrl.sv */
// controller driving the address and mode lines of the sample/hold array
// Functional notes
// - drive only one mode line low at a time, others high; with SINGLE_ONLY clear, all pending lines go low together.
// - simultaneous sampling lengthens sampling by the number sampling.
// - resample every held channel at least every 100 ms.
// - all lines hold while address changes; address never moves in sample.
// - address stays stable after hold rise and is set up beforehand.
// - one-at-a-time lines suit an active-low 2-to-4 decoder.
// - keep a mode line low at least 4 us per sample.
`timescale 1ns/1ps
`default_nettype none
module qoshc_ctrl
	import qoshc_pkg::*;
#(
	parameter int unsigned REFRESH_CYCLES = REFRESH_CYC_DEFAULT,
	parameter bit          SINGLE_ONLY    = 1'b1
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              start,
	input  wire logic [ADDR_W-1:0] start_address,
	input  wire logic [MUX_N-1:0]  start_mask,
	input  wire logic              refresh_clear,
	output logic                   busy,
	output logic                   done,
	output logic                   refresh_due,
	output logic [ADDR_W-1:0]      channel_address,
	output logic [MUX_N-1:0]       mux_mode_select
);
	logic               rst_meta_n;
	logic               rst_n_sync;
	qoshc_state_t       state;
	qoshc_state_t       next_state;
	logic [MUX_N-1:0]   pend;
	logic [MUX_N-1:0]   next_pend;
	logic [MUX_N-1:0]   group;
	logic [MUX_N-1:0]   next_group;
	logic [ADDR_W-1:0]  next_addr;
	logic [MUX_N-1:0]   next_mode;
	logic               next_busy;
	logic               next_done;
	logic               tmr_load;
	logic [TMR_W-1:0]   tmr_value;
	logic               tmr_expired;
	logic [RCNT_W-1:0]  rcnt;
	logic [RCNT_W-1:0]  next_rcnt;
	logic               next_due;
	logic               wrap;

	// ==================================================================
	// reset release
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_n <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n_sync <= rst_meta_n;
		end
	end

	// ==================================================================
	// helpers
	function automatic logic [MUX_N-1:0] lowest(input logic [MUX_N-1:0] m);
		lowest = m & MUX_N'(~m + 4'h1);
	endfunction

	function automatic logic [TMR_W-1:0] acq_len(input logic [MUX_N-1:0] m);
		logic [2:0] n;
		n = 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
		acq_len = TMR_W'(ACQ_CYC) * TMR_W'(n) - 16'h0001;
	endfunction

	qoshc_timer #(.W(TMR_W)) u_timer (
		.clk        (clk),
		.rst_n      (rst_n_sync),
		.load       (tmr_load),
		.load_value (tmr_value),
		.expired    (tmr_expired)
	);

	// ==================================================================
	// sequencer
	always_comb begin
		logic [MUX_N-1:0] grp;
		grp        = MASK_NONE;
		next_state = state;
		next_addr  = channel_address;
		next_mode  = mux_mode_select;
		next_pend  = pend;
		next_group = group;
		next_busy  = busy;
		next_done  = 1'b0;
		tmr_load   = 1'b0;
		tmr_value  = '0;
		case (state)
			ST_IDLE: begin
				next_mode = MODE_ALL_HOLD;
				if (start && start_mask != MASK_NONE) begin
					// address moves only while every line holds
					next_addr  = start_address;
					next_pend  = start_mask;
					next_busy  = 1'b1;
					next_state = ST_SETUP;
					tmr_load   = 1'b1;
					tmr_value  = TMR_W'(SETUP_CYC - 1);
				end
			end
			ST_SETUP: begin
				if (tmr_expired) begin
					grp        = SINGLE_ONLY ? lowest(pend) : pend;
					next_group = grp;
					next_mode  = ~grp;
					next_state = ST_SAMPLE;
					tmr_load   = 1'b1;
					tmr_value  = acq_len(grp);
				end
			end
			ST_SAMPLE: begin
				if (tmr_expired) begin
					next_mode  = MODE_ALL_HOLD;
					next_pend  = pend & ~group;
					next_state = ST_HOLD;
					tmr_load   = 1'b1;
					tmr_value  = TMR_W'(DH_CYC - 1);
				end
			end
			ST_HOLD: begin
				if (tmr_expired) begin
					if (pend != MASK_NONE) begin
						next_state = ST_SETUP;
						tmr_load   = 1'b1;
						tmr_value  = TMR_W'(SETUP_CYC - 1);
					end else begin
						next_state = ST_DONE;
					end
				end
			end
			ST_DONE: begin
				next_done  = 1'b1;
				next_busy  = 1'b0;
				next_state = ST_IDLE;
			end
			default: begin
				next_mode  = MODE_ALL_HOLD;
				next_busy  = 1'b0;
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			state           <= ST_IDLE;
			channel_address <= ADDR_RESET;
			mux_mode_select <= MODE_ALL_HOLD;
			pend            <= MASK_NONE;
			group           <= MASK_NONE;
			busy            <= 1'b0;
			done            <= 1'b0;
		end else begin
			state           <= next_state;
			channel_address <= next_addr;
			mux_mode_select <= next_mode;
			pend            <= next_pend;
			group           <= next_group;
			busy            <= next_busy;
			done            <= next_done;
		end
	end

	// ==================================================================
	// refresh period
	assign wrap = (rcnt == RCNT_W'(REFRESH_CYCLES - 1));

	always_comb begin
		next_rcnt = rcnt + 1'b1;
		if (refresh_clear || wrap) begin
			next_rcnt = '0;
		end
		// a period ending with the clear still flags
		next_due = wrap || (refresh_due && !refresh_clear);
	end

	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			rcnt        <= '0;
			refresh_due <= 1'b0;
		end else begin
			rcnt        <= next_rcnt;
			refresh_due <= next_due;
		end
	end

	// ==================================================================
	// checks
	logic [TMR_W-1:0] low_cnt;
	logic [TMR_W-1:0] addr_age;
	logic [TMR_W-1:0] high_age;
	logic [TMR_W-1:0] busy_age;
	wire              any_low = (mux_mode_select != MODE_ALL_HOLD);
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			low_cnt  <= '0;
			addr_age <= '0;
			high_age <= 16'hFFFF;
			busy_age <= '0;
		end else begin
			low_cnt  <= any_low ? low_cnt + 1'b1 : '0;
			busy_age <= busy ? busy_age + 1'b1 : '0;
			if (next_addr != channel_address) begin
				addr_age <= '0;
			end else if (addr_age != 16'hFFFF) begin
				addr_age <= addr_age + 1'b1;
			end
			if (any_low) begin
				high_age <= '0;
			end else if (high_age != 16'hFFFF) begin
				high_age <= high_age + 1'b1;
			end
		end
	end

	property p_single_low;
		@(posedge clk) disable iff (!rst_n_sync)
		SINGLE_ONLY |-> $countones(~mux_mode_select) <= 1;
	endproperty
	a_single_low: assert property (p_single_low)
		else $error("more than one mode line low");

	property p_decoder_code;
		@(posedge clk) disable iff (!rst_n_sync)
		SINGLE_ONLY |-> $onehot0(~mux_mode_select);
	endproperty
	a_decoder_code: assert property (p_decoder_code)
		else $error("mode lines not a decoder pattern");

	property p_acq_len;
		@(posedge clk) disable iff (!rst_n_sync)
		(!any_low && $past(any_low)) |->
			low_cnt >= ACQ_CYC * $countones(~$past(mux_mode_select));
	endproperty
	a_acq_len: assert property (p_acq_len)
		else $error("sample interval too short");

	property p_addr_still;
		@(posedge clk) disable iff (!rst_n_sync)
		any_low |-> $stable(channel_address);
	endproperty
	a_addr_still: assert property (p_addr_still)
		else $error("address moved while sampling");

	property p_addr_setup;
		@(posedge clk) disable iff (!rst_n_sync)
		$rose(any_low) |-> addr_age >= SETUP_CYC;
	endproperty
	a_addr_setup: assert property (p_addr_setup)
		else $error("address not set up before sampling");

	property p_addr_hold;
		@(posedge clk) disable iff (!rst_n_sync)
		$changed(channel_address) |-> high_age >= DH_CYC;
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("address changed too soon after hold");

	property p_refresh;
		@(posedge clk) disable iff (!rst_n_sync)
		wrap |=> refresh_due;
	endproperty
	a_refresh: assert property (p_refresh)
		else $error("refresh period end not flagged");

	property p_idle_hold;
		@(posedge clk) disable iff (!rst_n_sync)
		(state == ST_IDLE) |-> mux_mode_select == MODE_ALL_HOLD;
	endproperty
	a_idle_hold: assert property (p_idle_hold)
		else $error("mode line low while idle");
	property p_done_after;
		@(posedge clk) disable iff (!rst_n_sync)
		busy |-> busy_age <
			TMR_W'(MUX_N * (SETUP_CYC + MUX_N * ACQ_CYC + DH_CYC + 2));
	endproperty
	a_done_after: assert property (p_done_after)
		else $error("sequence did not finish");
	c_single: cover property (@(posedge clk) disable iff (!rst_n_sync)
		$rose(any_low) ##[1:1000] done);
	c_multi: cover property (@(posedge clk) disable iff (!rst_n_sync)
		$countones(~mux_mode_select) > 1);
	c_refresh: cover property (@(posedge clk) disable iff (!rst_n_sync)
		$rose(refresh_due));
endmodule
`default_nettype wire

/* File: hdl/qoshc_pkg.sv */
// constants for the sample/hold array controller
`default_nettype none
package qoshc_pkg;
	// ==================================================================
	// clock and timing figures
	localparam int T_CLK_NS     = 10;
	localparam int T_ACQ_NS     = 4000;
	localparam int T_PW_NS      = 100;
	localparam int T_DS_NS      = 100;
	localparam int T_DH_NS      = 100;
	localparam int T_REFRESH_MS = 100;
	// least times round up to whole cycles
	localparam int ACQ_CYC = (T_ACQ_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int PW_CYC  = (T_PW_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int DS_CYC  = (T_DS_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int DH_CYC  = (T_DH_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int SETUP_CYC = (PW_CYC > DS_CYC) ? PW_CYC : DS_CYC;
	// longest time rounds down
	localparam int REFRESH_CYC_DEFAULT = T_REFRESH_MS * 1000000 / T_CLK_NS;
	// ==================================================================
	// widths and fixed values
	localparam int ADDR_W  = 3;
	localparam int MUX_N   = 4;
	localparam int TMR_W   = 16;
	localparam int RCNT_W  = 32;
	localparam logic [MUX_N-1:0] MODE_ALL_HOLD = 4'hF;
	localparam logic [MUX_N-1:0] MASK_NONE     = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_RESET   = 3'h0;
	// ==================================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_HOLD   = 3'b011,
		ST_DONE   = 3'b100
	} qoshc_state_t;
endpackage
`default_nettype wire

/* File: hdl/qoshc_timer.sv */
// phase timer: loads a count, runs down, flags zero
`timescale 1ns/1ps
`default_nettype none
module qoshc_timer #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] load_value,
	output logic              expired
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;

	// ==================================================================
	// counter
	always_comb begin
		next_count = count;
		if (load) begin
			next_count = load_value;
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign expired = (count == '0);
endmodule
`default_nettype wire

/* File: verif/qoshc_array_model.sv */
// behavioural model of the 32-channel sample/hold array
`timescale 1ns/1ps
`default_nettype none
module qoshc_array_model
	import qoshc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [ADDR_W-1:0] channel_address,
	input  wire logic [MUX_N-1:0]  mux_mode_select,
	input  wire logic [7:0]        analog_inputs [MUX_N],
	output logic      [7:0]        held_outputs [32]
);
	initial begin
		for (int i = 0; i < 32; i++) begin
			held_outputs[i] = 8'h00;
		end
	end
	// ==================================================================
	// a low line copies its input to the addressed channel only
	always @(posedge clk) begin
		for (int m = 0; m < MUX_N; m++) begin
			if (mux_mode_select[m] === 1'b0) begin
				held_outputs[8*m + channel_address] <= analog_inputs[m];
			end
		end
	end
endmodule
`default_nettype wire

/* File: verif/quad_octal_sample_hold_control_bench.sv */
// self-checking bench for the sample/hold array controller
`timescale 1ns/1ps
`default_nettype none
module quad_octal_sample_hold_control_bench;
	import qoshc_pkg::*;
	localparam int REFRESH = 50;
	logic              clk = 1'b0;
	logic              rstn = 1'b0;
	logic              start = 1'b0;
	logic [ADDR_W-1:0] start_address = 3'h0;
	logic [MUX_N-1:0]  start_mask = 4'h0;
	logic              refresh_clear = 1'b0;
	logic              busy, done, refresh_due, busy2, done2, due2;
	logic [ADDR_W-1:0] channel_address, addr2, prev_addr;
	logic [MUX_N-1:0]  mux_mode_select, mode2, prev_mode;
	logic [7:0]        ain [MUX_N];
	logic [7:0]        held [32];
	int                miscompares = 0;
	int                checks_done = 0;
	int                low_cyc = 0, low2 = 0, falls = 0, bad = 0, ends2 = 0;
	int                since_rise = 99, since_addr = 99, l0, l2, f0, d0;

	always #5 clk = ~clk;

	qoshc_ctrl #(.REFRESH_CYCLES(REFRESH), .SINGLE_ONLY(1'b1)) i_dut (
		.clk(clk), .rstn(rstn), .start(start), .start_address(start_address),
		.start_mask(start_mask), .refresh_clear(refresh_clear), .busy(busy),
		.done(done), .refresh_due(refresh_due),
		.channel_address(channel_address), .mux_mode_select(mux_mode_select));
	qoshc_ctrl #(.REFRESH_CYCLES(REFRESH), .SINGLE_ONLY(1'b0)) i_dut_sim (
		.clk(clk), .rstn(rstn), .start(start), .start_address(start_address),
		.start_mask(start_mask), .refresh_clear(refresh_clear), .busy(busy2),
		.done(done2), .refresh_due(due2), .channel_address(addr2),
		.mux_mode_select(mode2));
	qoshc_array_model i_array (.clk(clk), .channel_address(channel_address),
		.mux_mode_select(mux_mode_select), .analog_inputs(ain),
		.held_outputs(held));

	// ==================================================================
	// pin monitor: sample length and address ordering
	always @(posedge clk) begin
		if (!rstn) begin
			prev_addr  <= ADDR_RESET;
			prev_mode  <= MODE_ALL_HOLD;
			since_rise <= 99;
			since_addr <= 99;
		end else begin
			prev_addr <= channel_address;
			prev_mode <= mux_mode_select;
			low_cyc <= low_cyc + $countones(~mux_mode_select);
			low2 <= low2 + ((mode2 == 4'h0) ? 1 : 0);
			ends2 <= ends2 + ((done2 === 1'b1) ? 1 : 0);
			since_rise <= (prev_mode != MODE_ALL_HOLD &&
				mux_mode_select == MODE_ALL_HOLD) ? 0 : since_rise + 1;
			since_addr <= (channel_address != prev_addr) ? 0 :
				since_addr + 1;
			if ($countones(~mux_mode_select) > 1) begin
				bad <= bad + 1;
			end
			if (channel_address != prev_addr &&
				(prev_mode != MODE_ALL_HOLD ||
				mux_mode_select != MODE_ALL_HOLD ||
				since_rise < DH_CYC - 1)) begin
				bad <= bad + 1;
			end
			if (prev_mode == MODE_ALL_HOLD &&
				mux_mode_select != MODE_ALL_HOLD) begin
				falls <= falls + 1;
				if (since_addr < SETUP_CYC - 1) begin
					bad <= bad + 1;
				end
			end
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic run(input logic [2:0] a, input logic [3:0] m);
		int n;
		n = 0;
		@(negedge clk);
		start_address = a;
		start_mask = m;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		while (done !== 1'b1 && n < 6000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 6000) begin
			miscompares++;
			end_sim();
		end
	endtask

	task automatic t_reset();
		repeat (3) @(negedge clk);
		check("mode after reset", mux_mode_select, MODE_ALL_HOLD);
		check("address after reset", channel_address, ADDR_RESET);
		check("busy after reset", busy, 1'b0);
		check("done after reset", done, 1'b0);
		check("refresh after reset", refresh_due, 1'b0);
	endtask

	task automatic t_single();
		l0 = low_cyc;
		f0 = falls;
		run(3'h5, 4'h1);
		check("single busy", busy, 1'b0);
		check("single low cycles", low_cyc - l0, ACQ_CYC);
		check("single groups", falls - f0, 1);
		check("sampled out5", held[5], ain[0]);
		check("unselected out13", held[13], 8'h00);
		check("unselected out4", held[4], 8'h00);
		@(negedge clk);
		check("done width", done, 1'b0);
	endtask

	task automatic t_multi();
		l0 = low_cyc;
		l2 = low2;
		f0 = falls;
		d0 = ends2;
		run(3'h7, 4'hF);
		check("joint busy", busy2, 1'b0);
		check("joint address", addr2, 3'h7);
		check("joint hold", mode2, MODE_ALL_HOLD);
		check("joint finishes", ends2 - d0, 1);
		check("multi low cycles", low_cyc - l0, 4 * ACQ_CYC);
		check("multi groups", falls - f0, 4);
		check("joint low cycles", low2 - l2, 4 * ACQ_CYC);
		for (int m = 0; m < MUX_N; m++) begin
			check("multi out", held[8*m + 7], ain[m]);
		end
	endtask

	task automatic t_refresh();
		@(negedge clk);
		refresh_clear = 1'b1;
		repeat (2) @(negedge clk);
		refresh_clear = 1'b0;
		check("refresh first clear", refresh_due, 1'b0);
		repeat (REFRESH - 1) @(negedge clk);
		check("refresh early", refresh_due, 1'b0);
		check("joint refresh early", due2, 1'b0);
		@(negedge clk);
		check("refresh due", refresh_due, 1'b1);
		check("joint refresh due", due2, 1'b1);
		refresh_clear = 1'b1;
		@(negedge clk);
		refresh_clear = 1'b0;
		check("refresh cleared", refresh_due, 1'b0);
		repeat (REFRESH - 1) @(negedge clk);
		refresh_clear = 1'b1;
		@(negedge clk);
		refresh_clear = 1'b0;
		check("refresh set wins", refresh_due, 1'b1);
	endtask

	initial begin
		for (int m = 0; m < MUX_N; m++) begin
			ain[m] = 8'h31 + 8'(m * 17);
		end
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		t_reset();
		t_single();
		t_multi();
		t_refresh();
		check("ordering faults", bad, 0);
		end_sim();
	end
endmodule
`default_nettype wire
